//--- hw/flyback_cycle_request_protection.sv
// Secondary-side cycle request, rectifier drive and protection control
// Function
// - Overshoot 2% enables low output bleed
// - Overshoot 20% switches bleed to high
// - Keep control while overshoot bleed active
// - Short at start: handshake, then request silence
// - Filtered feedback short stops requests
// - Long low feedback gives up control
// - Rectifier on only after requested forward fall
// - Current surge holds rectifier drive off
// - Switch on at start, off at limit
// - Started cycle always runs to completion
// - Free oscillator; decide at each period start
// - Current limit chosen from switch history
// - Exactly four current-limit states
// - Rectifier off just before each request
// - Low rectifier drop turns drive off
// - Switch and rectifier never conduct together
// - Fourteen misses or stray cycles rehandshake
// - Oscillator averages 100 kHz request clock
`timescale 1ns/10ps
`include "fcrp_cfg.svh"
module flyback_cycle_request_protection #(
   parameter logic [15:0] SILENCE_TICKS = `FCRP_SILENCE_TICKS,
   parameter logic [15:0] FB_RESTART_TICKS = `FCRP_FB_RESTART_TICKS
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic fb_below_reg,
   input wire logic fb_overshoot_lo,
   input wire logic fb_overshoot_hi,
   input wire logic fb_short,
   input wire logic fb_restart_low,
   input wire logic cs_over_threshold,
   input wire logic cs_surge,
   input wire logic forward_sense_input,
   input wire logic sr_drop_low,
   input wire logic switch_ilim_hit,
   output logic cycle_req_ff,
   output logic sync_rectifier_drive_ff,
   output logic power_switch_ff,
   output logic bleed_lo_ff,
   output logic bleed_hi_ff,
   output logic tick_ff,
   output fcrp_pkg::ctl_state_t ctl_state_ff,
   output fcrp_pkg::ilim_state_t ilim_state_ff
);
   import fcrp_pkg::*;

   logic [7:0] osc_cnt_ff;
   logic fwd_d_ff;
   logic fwd_fall;
   logic pend_ff;
   logic awaiting_ff;
   logic [3:0] miss_cnt_ff;
   logic surge_hold_ff;
   logic short_done;
   logic restart_done;
   logic silence_done;
   logic duty_done;
   logic bleeding;
   logic want_req;
   logic stray_fall;
   logic miss_now;
   ctl_state_t nxt_ctl_state;

   assign fwd_fall = fwd_d_ff & ~forward_sense_input;
   assign bleeding = bleed_lo_ff | bleed_hi_ff;
   assign stray_fall = fwd_fall & ~awaiting_ff & ~power_switch_ff;
   assign miss_now = tick_ff & awaiting_ff;

   // Free-running oscillator: one enable pulse per request period
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         osc_cnt_ff <= 8'h00;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (osc_cnt_ff == `FCRP_OSC_LAST);
         osc_cnt_ff <= (osc_cnt_ff == `FCRP_OSC_LAST) ? 8'h00 : osc_cnt_ff + 8'h01;
      end
   end

   // Feedback short deglitch, counted in clk cycles, under 10 us
   cyc_timer short_flt (
      .clk(clk),
      .rstn(rstn),
      .run(fb_short),
      .step(1'b1),
      .limit(`FCRP_DEGLITCH_CLKS),
      .done_ff(short_done)
   );

   // Feedback restart delay, counted in oscillator periods
   cyc_timer restart_dly (
      .clk(clk),
      .rstn(rstn),
      .run(fb_restart_low),
      .step(tick_ff),
      .limit(FB_RESTART_TICKS),
      .done_ff(restart_done)
   );

   // Request silence held long enough for the primary to auto-restart
   cyc_timer silence_dly (
      .clk(clk),
      .rstn(rstn),
      .run(ctl_state_ff == CTL_SILENCE),
      .step(tick_ff),
      .limit(SILENCE_TICKS),
      .done_ff(silence_done)
   );

   // Maximum on-time of the power switch within one period
   cyc_timer duty_lim (
      .clk(clk),
      .rstn(rstn),
      .run(power_switch_ff),
      .step(1'b1),
      .limit(`FCRP_MAX_DUTY_CLKS - 16'h0001),
      .done_ff(duty_done)
   );

   ilim_fsm ilim (
      .clk(clk),
      .rstn(rstn),
      .step(tick_ff),
      .switched(want_req),
      .ilim_state_ff(ilim_state_ff)
   );

   // Switch/skip decision sampled at the start of each period
   always_comb begin
      case (ctl_state_ff)
         CTL_HANDSHAKE: want_req = 1'b1;
         CTL_CONTROL: want_req = fb_below_reg & ~cs_over_threshold & ~bleeding;
         default: want_req = 1'b0;
      endcase
   end

   // Output bleed sink follows the two overshoot comparators
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bleed_lo_ff <= 1'b0;
         bleed_hi_ff <= 1'b0;
      end else begin
         bleed_lo_ff <= fb_overshoot_lo;
         bleed_hi_ff <= fb_overshoot_hi;
      end
   end

   // Request staged one clock behind the rectifier turn-off
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pend_ff <= 1'b0;
         cycle_req_ff <= 1'b0;
      end else begin
         pend_ff <= tick_ff & want_req;
         cycle_req_ff <= pend_ff;
      end
   end

   // Forward sense edge history and response tracking
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fwd_d_ff <= 1'b0;
         awaiting_ff <= 1'b0;
      end else begin
         fwd_d_ff <= forward_sense_input;
         if (cycle_req_ff) begin
            awaiting_ff <= 1'b1;
         end else if (fwd_fall || tick_ff) begin
            awaiting_ff <= 1'b0;
         end
      end
   end

   // Consecutive unanswered requests
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         miss_cnt_ff <= 4'h0;
      end else if (ctl_state_ff != CTL_CONTROL || (fwd_fall && awaiting_ff)) begin
         miss_cnt_ff <= 4'h0;
      end else if (miss_now && miss_cnt_ff != `FCRP_MISS_LIMIT) begin
         miss_cnt_ff <= miss_cnt_ff + 4'h1;
      end
   end

   // Surge lockout lasts until sensed current is back below threshold
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         surge_hold_ff <= 1'b0;
      end else if (cs_surge) begin
         surge_hold_ff <= 1'b1;
      end else if (!cs_over_threshold) begin
         surge_hold_ff <= 1'b0;
      end
   end

   // Synchronous rectifier drive
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_rectifier_drive_ff <= 1'b0;
      end else if (cs_surge || surge_hold_ff) begin
         sync_rectifier_drive_ff <= 1'b0;
      end else if (tick_ff && want_req) begin
         sync_rectifier_drive_ff <= 1'b0;
      end else if (sr_drop_low) begin
         sync_rectifier_drive_ff <= 1'b0;
      end else if (fwd_fall && awaiting_ff && !pend_ff && !power_switch_ff) begin
         sync_rectifier_drive_ff <= 1'b1;
      end
   end

   // Power switch: on at cycle start, off at current or duty limit only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         power_switch_ff <= 1'b0;
      end else if (power_switch_ff) begin
         if (switch_ilim_hit || duty_done) begin
            power_switch_ff <= 1'b0;
         end
      end else if (cycle_req_ff && !sync_rectifier_drive_ff) begin
         power_switch_ff <= 1'b1;
      end
   end

   // Control ownership sequence
   always_comb begin
      nxt_ctl_state = ctl_state_ff;
      case (ctl_state_ff)
         CTL_HANDSHAKE: begin
            if (fwd_fall && awaiting_ff) begin
               nxt_ctl_state = fb_short ? CTL_SILENCE : CTL_CONTROL;
            end
         end
         CTL_CONTROL: begin
            if (restart_done && !bleeding) begin
               nxt_ctl_state = CTL_RELEASED;
            end else if (short_done) begin
               nxt_ctl_state = CTL_SILENCE;
            end else if (stray_fall) begin
               nxt_ctl_state = CTL_HANDSHAKE;
            end else if (miss_now && miss_cnt_ff == `FCRP_MISS_LIMIT - 4'h1) begin
               nxt_ctl_state = CTL_HANDSHAKE;
            end
         end
         CTL_SILENCE: begin
            if (silence_done) begin
               nxt_ctl_state = CTL_HANDSHAKE;
            end
         end
         CTL_RELEASED: begin
            if (!fb_restart_low) begin
               nxt_ctl_state = CTL_HANDSHAKE;
            end
         end
         default: nxt_ctl_state = CTL_HANDSHAKE;
      endcase
   end

   // Control state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl_state_ff <= CTL_HANDSHAKE;
      end else begin
         ctl_state_ff <= nxt_ctl_state;
      end
   end

   // Checks on the guarded behaviour
   bleed_low_a: assert property (@(posedge clk) disable iff (!rstn)
      fb_overshoot_lo |=> bleed_lo_ff) else $error("low bleed not enabled");
   bleed_high_a: assert property (@(posedge clk) disable iff (!rstn)
      fb_overshoot_hi |=> bleed_hi_ff) else $error("high bleed not enabled");
   bleed_keeps_a: assert property (@(posedge clk) disable iff (!rstn)
      (ctl_state_ff == CTL_CONTROL && bleeding) |=> ctl_state_ff != CTL_RELEASED)
      else $error("control released during bleed");
   silence_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
      (ctl_state_ff == CTL_SILENCE) [*3] |-> !cycle_req_ff) else $error("request in silence");
   short_stops_a: assert property (@(posedge clk) disable iff (!rstn)
      (ctl_state_ff == CTL_CONTROL && short_done && !restart_done) |=>
      ctl_state_ff == CTL_SILENCE) else $error("short did not stop requests");
   restart_gives_a: assert property (@(posedge clk) disable iff (!rstn)
      (ctl_state_ff == CTL_CONTROL && restart_done && !bleeding) |=>
      ctl_state_ff == CTL_RELEASED) else $error("control not given up");
   sr_gate_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(sync_rectifier_drive_ff) |-> $past(fwd_fall) && $past(awaiting_ff))
      else $error("rectifier on without requested edge");
   surge_off_a: assert property (@(posedge clk) disable iff (!rstn)
      cs_surge |=> !sync_rectifier_drive_ff ##1 !sync_rectifier_drive_ff)
      else $error("rectifier on during surge");
   duty_stop_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(power_switch_ff) |-> ##[1:170] !power_switch_ff) else $error("switch exceeds duty");
   tick_period_a: assert property (@(posedge clk) disable iff (!rstn)
      tick_ff |=> !tick_ff [*8]) else $error("oscillator period too short");
   sr_before_req_a: assert property (@(posedge clk) disable iff (!rstn)
      cycle_req_ff |-> !sync_rectifier_drive_ff && !$past(sync_rectifier_drive_ff))
      else $error("request while rectifier on");
   no_overlap_a: assert property (@(posedge clk) disable iff (!rstn)
      !(sync_rectifier_drive_ff && power_switch_ff)) else $error("cross conduction");
   miss_rehand_a: assert property (@(posedge clk) disable iff (!rstn)
      (ctl_state_ff == CTL_CONTROL && miss_now && miss_cnt_ff == 4'hD && !restart_done &&
      !short_done) |=> ctl_state_ff == CTL_HANDSHAKE) else $error("no rehandshake");
endmodule : flyback_cycle_request_protection

//--- shared/fcrp_cfg.svh
// Timing counts and limits for the flyback cycle request and protection block
`ifndef FCRP_CFG_SVH
`define FCRP_CFG_SVH
`define FCRP_CLK_HZ 25000000
`define FCRP_CLK_NS 40
`define FCRP_OSC_HZ 100000
`define FCRP_OSC_DIV (`FCRP_CLK_HZ / `FCRP_OSC_HZ)
`define FCRP_OSC_LAST 8'(`FCRP_OSC_DIV - 1)
`define FCRP_DEGLITCH_NS 10000
`define FCRP_DEGLITCH_CLKS 16'((`FCRP_DEGLITCH_NS / `FCRP_CLK_NS) - 1)
`define FCRP_MAX_DUTY_PCT 64
`define FCRP_MAX_DUTY_CLKS 16'((`FCRP_OSC_DIV * `FCRP_MAX_DUTY_PCT) / 100)
`define FCRP_MISS_LIMIT 4'hE
`define FCRP_HIST_LEN 8
`define FCRP_ILIM_HIGH_MIN 4'h7
`define FCRP_ILIM_MIDHI_MIN 4'h5
`define FCRP_ILIM_MIDLO_MIN 4'h3
`define FCRP_SILENCE_TICKS 16'h0064
`define FCRP_FB_RESTART_TICKS 16'h0032
`endif

//--- shared/fcrp_pkg.sv
// Types shared by the flyback cycle request and protection block
package fcrp_pkg;
   typedef enum logic [3:0] {
      CTL_HANDSHAKE = 4'h1,
      CTL_CONTROL   = 4'h2,
      CTL_SILENCE   = 4'h4,
      CTL_RELEASED  = 4'h8
   } ctl_state_t;
   typedef enum logic [3:0] {
      ILIM_LOW   = 4'h1,
      ILIM_MIDLO = 4'h2,
      ILIM_MIDHI = 4'h4,
      ILIM_HIGH  = 4'h8
   } ilim_state_t;
endpackage : fcrp_pkg

//--- hw/cyc_timer.sv
// Step counter that flags when a running condition has lasted a set count
`timescale 1ns/10ps
module cyc_timer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic step,
   input wire logic [15:0] limit,
   output logic done_ff
);
   logic [15:0] cnt_ff;

   // Count steps while run holds; restart from zero when it drops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= 16'h0000;
         done_ff <= 1'b0;
      end else if (!run) begin
         cnt_ff <= 16'h0000;
         done_ff <= 1'b0;
      end else if (step && !done_ff) begin
         if (cnt_ff >= limit - 16'h0001) begin
            done_ff <= 1'b1;
         end else begin
            cnt_ff <= cnt_ff + 16'h0001;
         end
      end
   end
endmodule : cyc_timer

//--- hw/ilim_fsm.sv
// Current-limit state machine driven by the switch/skip history
`timescale 1ns/10ps
`include "fcrp_cfg.svh"
module ilim_fsm (
   input wire logic clk,
   input wire logic rstn,
   input wire logic step,
   input wire logic switched,
   output fcrp_pkg::ilim_state_t ilim_state_ff
);
   import fcrp_pkg::*;

   logic [`FCRP_HIST_LEN-1:0] hist_ff;
   ilim_state_t nxt_ilim_state;

   function automatic logic [3:0] count_ones(input logic [`FCRP_HIST_LEN-1:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < `FCRP_HIST_LEN; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction : count_ones

   // Sliding window of switch decisions, one bit per oscillator period
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hist_ff <= '0;
      end else if (step) begin
         hist_ff <= {hist_ff[`FCRP_HIST_LEN-2:0], switched};
      end
   end

   // Four limits; a denser switching pattern selects a higher limit
   always_comb begin
      logic [3:0] ones;
      ones = count_ones(hist_ff);
      if (ones >= `FCRP_ILIM_HIGH_MIN) begin
         nxt_ilim_state = ILIM_HIGH;
      end else if (ones >= `FCRP_ILIM_MIDHI_MIN) begin
         nxt_ilim_state = ILIM_MIDHI;
      end else if (ones >= `FCRP_ILIM_MIDLO_MIN) begin
         nxt_ilim_state = ILIM_MIDLO;
      end else begin
         nxt_ilim_state = ILIM_LOW;
      end
   end

   // Limit changes only at a period boundary so a cycle keeps its limit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ilim_state_ff <= ILIM_HIGH;
      end else if (step) begin
         ilim_state_ff <= nxt_ilim_state;
      end
   end
endmodule : ilim_fsm

//--- sim/primary_model.sv
// Behavioural primary-side switch controller facing the cycle request link
`timescale 1ns/10ps
module primary_model #(
   parameter int SILENCE_CLKS = 700 // Clocks without requests before auto-restart
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cycle_req,
   input wire logic power_switch,
   input wire logic mute,
   input wire logic stray,
   input wire logic no_limit,
   input wire logic [7:0] lag,
   output logic fwd_ff,
   output logic ilim_hit,
   output logic restarted_ff
);
   logic [7:0] cnt_ff;
   logic busy_ff;
   logic [7:0] on_ff;
   logic [15:0] quiet_ff;

   // Auto-restart once no request has arrived for longer than the silence time
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         quiet_ff <= 16'h0000;
         restarted_ff <= 1'b0;
      end else if (cycle_req && !mute) begin
         quiet_ff <= 16'h0000;
         restarted_ff <= 1'b0;
      end else if (quiet_ff >= 16'(SILENCE_CLKS)) begin
         restarted_ff <= 1'b1;
      end else begin
         quiet_ff <= quiet_ff + 16'h0001;
      end
   end

   // A request, or a commanded stray cycle, gives one forward pulse after lag clocks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy_ff <= 1'b0;
         cnt_ff <= 8'h00;
         fwd_ff <= 1'b0;
      end else if (!busy_ff) begin
         busy_ff <= (cycle_req && !mute) || stray;
         cnt_ff <= 8'h00;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
         fwd_ff <= (cnt_ff >= lag) && (cnt_ff < lag + 8'h32);
         busy_ff <= (cnt_ff < lag + 8'h33);
      end
   end

   // Switch current reaches the limit after 40 clocks of on-time, unless suppressed
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         on_ff <= 8'h00;
      end else begin
         on_ff <= power_switch ? on_ff + 8'h01 : 8'h00;
      end
   end
   assign ilim_hit = !no_limit && (on_ff >= 8'h28);
endmodule : primary_model

//--- sim/flyback_cycle_request_protection_tb_top.sv
// Self-checking bench for the flyback cycle request and protection block
`timescale 1ns/10ps
module flyback_cycle_request_protection_tb_top;
   import fcrp_pkg::*;
   logic clk, rstn, fb_below_reg, fb_overshoot_lo, fb_overshoot_hi, fb_short, fb_restart_low;
   logic cs_over_threshold, cs_surge, forward_sense_input, sr_drop_low, switch_ilim_hit;
   logic cycle_req_ff, sync_rectifier_drive_ff, power_switch_ff, bleed_lo_ff, bleed_hi_ff;
   logic tick_ff, mute, stray, no_limit, prim_restarted;
   logic [7:0] lag;
   ctl_state_t ctl_state_ff;
   ilim_state_t ilim_state_ff;
   int n_errors = 0, num_checks = 0, sr_rises = 0, on_cnt = 0;
   logic p_sw = 0, p_ilim = 0, p_surge = 0, p_drop = 0, p_drv = 0, p_fwd = 0;
   logic armed = 0, fell_ok = 0;

   flyback_cycle_request_protection #(.SILENCE_TICKS(16'h0003), .FB_RESTART_TICKS(16'h0003)) uut (
      .clk, .rstn, .fb_below_reg, .fb_overshoot_lo, .fb_overshoot_hi, .fb_short,
      .fb_restart_low, .cs_over_threshold, .cs_surge, .forward_sense_input, .sr_drop_low,
      .switch_ilim_hit, .cycle_req_ff, .sync_rectifier_drive_ff, .power_switch_ff,
      .bleed_lo_ff, .bleed_hi_ff, .tick_ff, .ctl_state_ff, .ilim_state_ff);

   primary_model prim (.clk(clk), .rstn(rstn), .cycle_req(cycle_req_ff),
      .power_switch(power_switch_ff), .mute(mute), .stray(stray), .no_limit(no_limit),
      .lag(lag), .fwd_ff(forward_sense_input), .ilim_hit(switch_ilim_hit),
      .restarted_ff(prim_restarted));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   // Current limit expected from the last eight decisions
   function automatic ilim_state_t ilim_exp(logic [7:0] h);
      int c;
      c = $countones(h);
      if (c >= 7) return ILIM_HIGH;
      if (c >= 5) return ILIM_MIDHI;
      if (c >= 3) return ILIM_MIDLO;
      return ILIM_LOW;
   endfunction : ilim_exp

   task automatic wait_tick(output int k);
      for (k = 1; k <= 300; k++) begin
         @(negedge clk);
         if (tick_ff === 1'b1) break;
      end
      if (k > 300) check("tick_wait", 0, 1);
   endtask : wait_tick

   task automatic wait_state(ctl_state_t st, int periods);
      for (int k = 0; k < periods * 250 && ctl_state_ff !== st; k++) @(negedge clk);
      check("ctl_state", ctl_state_ff, st);
   endtask : wait_state

   task automatic count_reqs(int periods, output int n);
      n = 0;
      repeat (periods * 250) begin
         @(negedge clk);
         if (cycle_req_ff === 1'b1) n++;
      end
   endtask : count_reqs

   // Cycle-level watch on rectifier and switch against their causes
   always @(negedge clk) begin
      if (rstn) begin
         check("overlap", power_switch_ff && sync_rectifier_drive_ff, 0);
         if (cycle_req_ff) check("sr_at_req", sync_rectifier_drive_ff, 0);
         if (p_surge) check("sr_surge", sync_rectifier_drive_ff, 0);
         if (p_drop) check("sr_drop", sync_rectifier_drive_ff, 0);
         if (p_ilim && p_sw) check("sw_off", power_switch_ff, 0);
         if (p_sw && !power_switch_ff) check("sw_early", p_ilim || on_cnt >= 160, 1);
         if (power_switch_ff) check("sw_duty", on_cnt < 160, 1);
         if (sync_rectifier_drive_ff && !p_drv) check("sr_cause", fell_ok, 1);
         if (sync_rectifier_drive_ff && !p_drv) sr_rises++;
         if (cycle_req_ff) begin
            armed = 1'b1;
            fell_ok = 1'b0;
         end else if (armed && p_fwd && !forward_sense_input) begin
            armed = 1'b0;
            fell_ok = 1'b1;
         end
         if (sync_rectifier_drive_ff && !p_drv) fell_ok = 1'b0;
         on_cnt = power_switch_ff ? on_cnt + 1 : 0;
      end
      {p_sw, p_ilim, p_surge, p_drop} = {power_switch_ff, switch_ilim_hit, cs_surge, sr_drop_low};
      {p_drv, p_fwd} = {sync_rectifier_drive_ff, forward_sense_input};
   end

   // Watchdog against a hang
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      logic [7:0] hist;
      logic [1:0] b;
      logic want, nxt, co;
      int k, n;
      {fb_below_reg, fb_overshoot_lo, fb_overshoot_hi, fb_short, fb_restart_low} = 5'h10;
      {cs_over_threshold, cs_surge, sr_drop_low, mute, stray, no_limit} = 6'h00;
      lag = 8'h04;
      rstn = 1'b0;
      hist = 8'h00;
      want = 1'b1;
      void'($urandom(32'hDAFF6F1D));
      repeat (12) @(posedge clk);
      check("ctl_rst", ctl_state_ff, CTL_HANDSHAKE);
      check("ilim_rst", ilim_state_ff, ILIM_HIGH);
      check("out_rst", {cycle_req_ff, sync_rectifier_drive_ff, power_switch_ff}, 0);
      rstn <= 1'b1;
      for (k = 1; k < 300; k++) begin
         @(posedge clk);
         #1;
         if (tick_ff === 1'b1) break;
      end
      check("tick_first", k, 250);
      @(negedge clk);
      wait_tick(n);
      check("tick_period", n, 250);
      wait_state(CTL_CONTROL, 3);
      // Random load pattern: request timing and current-limit history
      for (int i = 0; i < 24; i++) begin
         wait_tick(n);
         @(negedge clk);
         @(negedge clk);
         check("req", cycle_req_ff, want);
         // The limit registered at this tick reflects the eight earlier decisions
         if (i >= 8) check("ilim", ilim_state_ff, ilim_exp(hist));
         hist = {hist[6:0], want};
         @(posedge clk);
         nxt = 1'($urandom_range(1));
         co = ($urandom_range(3) == 0);
         want = nxt & !co;
         fb_below_reg <= nxt;
         cs_over_threshold <= co;
         cs_surge <= ($urandom_range(4) == 0);
         sr_drop_low <= ($urandom_range(4) == 0);
         lag <= 8'($urandom_range(40, 2));
         no_limit <= ($urandom_range(3) == 0);
      end
      @(posedge clk) {fb_below_reg, cs_over_threshold, cs_surge, sr_drop_low, no_limit} <= 5'h10;
      check("sr_seen", sr_rises > 0, 1);
      // Bleed levels for every comparator combination
      for (int i = 0; i < 8; i++) begin
         b = 2'(i);
         @(posedge clk);
         {fb_overshoot_hi, fb_overshoot_lo} <= b;
         @(posedge clk);
         @(negedge clk);
         check("bleed_lo", bleed_lo_ff, b[0]);
         check("bleed_hi", bleed_hi_ff, b[1]);
      end
      @(posedge clk);
      {fb_overshoot_hi, fb_overshoot_lo, fb_restart_low} <= 3'h3;
      count_reqs(5, n);
      check("bleed_reqs", n, 0);
      check("bleed_ctl", ctl_state_ff, CTL_CONTROL);
      @(posedge clk) fb_overshoot_lo <= 1'b0;
      wait_state(CTL_RELEASED, 2);
      count_reqs(2, n);
      check("rel_reqs", n, 0);
      @(posedge clk) fb_restart_low <= 1'b0;
      wait_state(CTL_HANDSHAKE, 2);
      wait_state(CTL_CONTROL, 3);
      // Unanswered requests
      @(posedge clk) mute <= 1'b1;
      for (int i = 0; i < 12; i++) wait_tick(n);
      check("miss12", ctl_state_ff, CTL_CONTROL);
      wait_state(CTL_HANDSHAKE, 4);
      @(posedge clk) mute <= 1'b0;
      wait_state(CTL_CONTROL, 3);
      // Stray primary cycle with no request
      @(posedge clk) fb_below_reg <= 1'b0;
      wait_tick(n);
      wait_tick(n);
      repeat (10) @(posedge clk);
      stray <= 1'b1;
      @(posedge clk) stray <= 1'b0;
      wait_state(CTL_HANDSHAKE, 1);
      @(posedge clk) fb_below_reg <= 1'b1;
      wait_state(CTL_CONTROL, 3);
      check("prim_quiet", prim_restarted, 0);
      // Feedback short in control, then at handshake
      @(posedge clk) fb_short <= 1'b1;
      for (k = 1; k < 600 && ctl_state_ff !== CTL_SILENCE; k++) @(negedge clk);
      check("short_delay", k > 200 && k <= 252, 1);
      count_reqs(2, n);
      check("silent_reqs", n, 0);
      wait_state(CTL_HANDSHAKE, 2);
      check("prim_restart", prim_restarted, 1);
      wait_state(CTL_SILENCE, 3);
      @(posedge clk) fb_short <= 1'b0;
      wait_state(CTL_CONTROL, 8);
      tally_and_finish();
   end
endmodule : flyback_cycle_request_protection_tb_top
